// ==== verilog/ces_config_supervisor.sv ====
// Configuration error supervisor: frame CRC check, brown-out and chain error handling
`timescale 1ns/10ps

module ces_config_supervisor (
    input wire logic mclk,                  // System clock
    input wire logic nrst,                  // Async reset, active low
    input wire logic cfg_clk,               // Link configuration clock
    input wire logic serial_config_data,    // Serial config data, LSB first
    input wire logic config_request_n,      // Configuration request pin
    input wire logic chain_enable_n,        // Chain enable pin
    input wire logic supply_ok,             // Supply above brown-out threshold
    input wire logic scan_active,           // Boundary-scan configuration active
    input wire logic config_error_flag_n_i, // Shared status line level
    output logic config_error_flag_n_o,     // Drive value, always low
    output logic config_error_flag_n_oe,    // Drive enable of status line
    output logic frame_ok,                  // Pulse per good frame
    output logic config_active,             // Accepting configuration data
    output logic [7:0] frame_count          // Good frames since start
);
    import ces_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] req_s_q, ce_s_q, sup_s_q, scan_s_q, stat_s_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_s_q <= CES_SYNC_RST;
            ce_s_q <= CES_SYNC_SET;
            sup_s_q <= CES_SYNC_RST;
            scan_s_q <= CES_SYNC_RST;
            stat_s_q <= CES_SYNC_SET;
        end else begin
            req_s_q <= {req_s_q[0], config_request_n};
            ce_s_q <= {ce_s_q[0], chain_enable_n};
            sup_s_q <= {sup_s_q[0], supply_ok};
            scan_s_q <= {scan_s_q[0], scan_active};
            stat_s_q <= {stat_s_q[0], config_error_flag_n_i};
        end
    end
    logic req_high, sup_ok, scan_on, stat_low, ce_low;
    assign req_high = req_s_q[1];
    assign sup_ok = sup_s_q[1];
    assign scan_on = scan_s_q[1];
    assign stat_low = ~stat_s_q[1];
    assign ce_low = ~ce_s_q[1];

    // ----------------------------------------
    // Control state machine (mclk domain)
    // ----------------------------------------
    ces_state_t state_q;
    logic load_en_q;
    logic [7:0] pulse_q;
    logic [7:0] frame_count_q;
    logic frame_ok_q;
    logic flag_pulse_d;
    logic ev_good, ev_bad;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CES_IDLE;
        end else if (!sup_ok) begin
            state_q <= CES_BROWN;
        end else begin
            case (state_q)
                CES_IDLE: begin
                    // Start only when requested, enabled, no scan and line released
                    if (req_high && ce_low && !scan_on && !stat_low) begin
                        state_q <= CES_LOAD;
                    end
                end
                CES_LOAD: begin
                    if (scan_on) begin
                        state_q <= CES_IDLE;
                    end else if (ev_bad) begin
                        state_q <= CES_HALT;
                    end else if (stat_low && pulse_q == 8'h00) begin
                        state_q <= CES_IDLE;
                    end else if (!req_high) begin
                        state_q <= CES_IDLE;
                    end
                end
                CES_HALT: begin
                    // Own pulse must end and the shared line return high
                    if (pulse_q == 8'h00 && !stat_low) begin
                        state_q <= CES_IDLE;
                    end
                end
                default: begin
                    // Recovered supply: tied-high request restarts once the error pulse on the line has ended
                    state_q <= CES_IDLE;
                end
            endcase
        end
    end

    // Error pulse timer; brown-out holds the line low while supply is bad
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= 8'h00;
        end else if (!sup_ok || (state_q == CES_LOAD && ev_bad)) begin
            pulse_q <= CES_ERR_PULSE_CNT;
        end else if (pulse_q != 8'h00) begin
            pulse_q <= pulse_q - 8'h01;
        end
    end
    assign flag_pulse_d = (pulse_q != 8'h00) || (state_q == CES_BROWN);
    // Low pulse on status also resets the loader wired to it
    assign config_error_flag_n_o = 1'b0;
    assign config_error_flag_n_oe = flag_pulse_d;

    // Drops at the same edge that a bad frame arrives
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            load_en_q <= 1'b0;
        end else begin
            load_en_q <= (state_q == CES_LOAD) && !ev_bad && !scan_on;
        end
    end
    assign config_active = load_en_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            frame_count_q <= CES_FRAME_CNT_RST;
            frame_ok_q <= 1'b0;
        end else begin
            frame_ok_q <= ev_good && state_q == CES_LOAD;
            if (state_q != CES_LOAD) begin
                frame_count_q <= CES_FRAME_CNT_RST;
            end else if (ev_good) begin
                frame_count_q <= frame_count_q + 8'h01;
            end
        end
    end
    assign frame_ok = frame_ok_q;
    assign frame_count = frame_count_q;

    // ----------------------------------------
    // Link side (cfg_clk domain)
    // ----------------------------------------
    // Gated link clock: the enable only crosses on link edges
    logic [1:0] en_s_q;
    logic [6:0] bit_q;
    logic [15:0] crc_q, rx_crc_q;
    logic good_t_q, bad_t_q;

    always_ff @(posedge cfg_clk or negedge nrst) begin
        if (!nrst) begin
            en_s_q <= CES_SYNC_RST;
        end else begin
            en_s_q <= {en_s_q[0], load_en_q};
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
        logic fb;
        fb = c[15] ^ d;
        crc_step = {c[14:0], 1'b0} ^ (fb ? CES_CRC_POLY : 16'h0000);
    endfunction

    // Bits 0 to 63 feed the CRC, the last 16 carry it
    logic [15:0] rx_crc_next;
    assign rx_crc_next = {serial_config_data, rx_crc_q[15:1]};

    always_ff @(posedge cfg_clk or negedge nrst) begin
        if (!nrst) begin
            bit_q <= 7'h00;
            crc_q <= CES_CRC_INIT;
            rx_crc_q <= 16'h0000;
            good_t_q <= 1'b0;
            bad_t_q <= 1'b0;
        end else if (!en_s_q[1]) begin
            bit_q <= 7'h00;
            crc_q <= CES_CRC_INIT;
            rx_crc_q <= 16'h0000;
        end else if (bit_q < 7'(CES_FRAME_BITS)) begin
            crc_q <= crc_step(crc_q, serial_config_data);
            bit_q <= bit_q + 7'h01;
        end else if (bit_q < 7'(CES_FRAME_BITS + CES_CRC_BITS - 1)) begin
            rx_crc_q <= rx_crc_next;
            bit_q <= bit_q + 7'h01;
        end else begin
            bit_q <= 7'h00;
            crc_q <= CES_CRC_INIT;
            rx_crc_q <= 16'h0000;
            if (rx_crc_next == crc_q) begin
                good_t_q <= ~good_t_q;
            end else begin
                bad_t_q <= ~bad_t_q;
            end
        end
    end

    // Toggle events back into mclk
    logic [2:0] good_s_q, bad_s_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            good_s_q <= 3'h0;
            bad_s_q <= 3'h0;
        end else begin
            good_s_q <= {good_s_q[1:0], good_t_q};
            bad_s_q <= {bad_s_q[1:0], bad_t_q};
        end
    end
    assign ev_good = good_s_q[2] ^ good_s_q[1];
    assign ev_bad = bad_s_q[2] ^ bad_s_q[1];
endmodule

// ==== verilog/ces_pkg.sv ====
// Constants and types for the configuration error supervisor
package ces_pkg;
    localparam int unsigned CES_MCLK_HZ = 20000000;
    // Frame layout: payload bits then CRC bits, LSB first
    localparam int unsigned CES_FRAME_BITS = 64;
    localparam int unsigned CES_CRC_BITS = 16;
    localparam logic [15:0] CES_CRC_POLY = 16'h8005;
    localparam logic [15:0] CES_CRC_INIT = 16'hffff;
    localparam logic [7:0] CES_FRAME_CNT_RST = 8'h00;
    // Status pulse length on an error, set in ns and rounded up to mclk cycles
    localparam int unsigned CES_ERR_PULSE_NS = 2000;
    localparam int unsigned CES_ERR_PULSE_CYC = (CES_ERR_PULSE_NS * (CES_MCLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] CES_ERR_PULSE_CNT = 8'(CES_ERR_PULSE_CYC);
    localparam logic [1:0] CES_SYNC_RST = 2'h0;
    localparam logic [1:0] CES_SYNC_SET = 2'h3;
    typedef enum logic [1:0] {
        CES_IDLE,
        CES_LOAD,
        CES_HALT,
        CES_BROWN
    } ces_state_t;
endpackage

// ==== tb/ces_sup_sva.sv ====
// Port assertions for the configuration error supervisor
`timescale 1ns/10ps
module ces_sup_sva (
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset
    input wire logic config_request_n, // Request
    input wire logic supply_ok, // Supply
    input wire logic scan_active, // Scan
    input wire logic config_error_flag_n_i, // Wire
    input wire logic config_error_flag_n_o, // Drive
    input wire logic config_error_flag_n_oe, // Enable
    input wire logic config_active // Loading
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence brown_s; !supply_ok [*5]; endsequence
    sequence err_s; $rose(config_error_flag_n_oe); endsequence
    drive_low_a: assert property (config_error_flag_n_oe |-> !config_error_flag_n_o) else $error("drive");
    err_hold_a: assert property (err_s |-> config_error_flag_n_oe [*8]) else $error("short");
    halt_a: assert property (err_s |-> ##[0:4] !config_active) else $error("halt");
    brown_flag_a: assert property (brown_s |-> config_error_flag_n_oe) else $error("brown");
    brown_stop_a: assert property (brown_s |-> !config_active) else $error("run");
    scan_prio_a: assert property (scan_active [*5] |-> !config_active) else $error("scan");
    chain_rst_a: assert property (!config_error_flag_n_i [*6] |-> !config_active) else $error("chain");
    restart_a: assert property ($rose(supply_ok) && config_request_n && !scan_active |-> ##[1:120] config_active)
        else $error("restart");
endmodule
bind ces_config_supervisor ces_sup_sva chk (.mclk, .nrst, .config_request_n, .supply_ok, .scan_active,
    .config_error_flag_n_i, .config_error_flag_n_o, .config_error_flag_n_oe, .config_active);

// ==== tb/ces_loader_model.sv ====
// Loader model: CRC frames on a gated link clock, completion timeout
`timescale 1ns/10ps
module ces_loader_model import ces_pkg::*; (
    output logic cfg_clk, // Link clock
    output logic serial_config_data, // Data
    output logic loader_err, // Status pull
    input wire logic loader_select_n // Done
);
    logic [15:0] crc;
    initial {cfg_clk, serial_config_data, loader_err} = 3'h0;
    task automatic tick(input logic b);
        serial_config_data = b;
        #32 cfg_clk = 1;
        #32 cfg_clk = 0;
    endtask
    task automatic send_frame(input logic [63:0] p, input int mode);
        crc = CES_CRC_INIT;
        for (int i = 0; i < 64; i++) begin
            crc = {crc[14:0], 1'b0} ^ (crc[15] ^ p[i] ? CES_CRC_POLY : 16'h0000);
            tick(mode == 2 ? p[63 - i] : p[i]);
        end
        for (int i = 0; i < 16; i++) begin
            tick(crc[i] ^ (mode == 1 && i == 0));
        end
        serial_config_data = ~serial_config_data;
    endtask
    task automatic finish_load(input int limit);
        for (int n = 0; n < limit && !loader_select_n; n++) begin
            tick(n[0]);
        end
        loader_err = !loader_select_n;
        repeat (8) tick(1'b0);
        loader_err = 0;
    endtask
endmodule

// ==== tb/tb.sv ====
// Bench for the configuration error supervisor
`timescale 1ns/10ps
module tb;
    logic mclk = 0, nrst = 0, supply_ok = 1, scan_active = 0;
    logic config_request_n = 1, chain_enable_n = 1, loader_select_n = 0;
    wire logic cfg_clk, serial_config_data, loader_err, config_error_flag_n_o, config_error_flag_n_oe;
    wire logic frame_ok, config_active;
    wire logic [7:0] frame_count;
    // Pulled-up shared status: device drives its value when enabled, loader pulls low
    wire logic config_error_flag_n_i = !loader_err && (config_error_flag_n_oe ? config_error_flag_n_o : 1'b1);
    int num_errors = 0, compares = 0, cyc = 0, oks, errs, lows, ticks = 0, waited = 0;
    ces_config_supervisor uut (.mclk, .nrst, .cfg_clk, .serial_config_data, .config_request_n,
        .chain_enable_n, .supply_ok, .scan_active, .config_error_flag_n_i, .config_error_flag_n_o,
        .config_error_flag_n_oe, .frame_ok, .config_active, .frame_count);
    ces_loader_model m (.cfg_clk, .serial_config_data, .loader_err, .loader_select_n);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always #25 mclk = ~mclk;
    always @(posedge cfg_clk) ticks++;
    always @(posedge loader_err) waited = ticks;
    always @(posedge mclk) begin
        cyc++;
        oks += frame_ok === 1'b1;
        errs += config_error_flag_n_i === 1'b0;
        lows += config_active === 1'b0;
        if (cyc == 20000) begin
            num_errors++;
            $display("MISMATCH %0t hang", $time);
            complete_run();
        end
    end
    initial begin
        void'($urandom(54));
        repeat (2) @(negedge mclk);
        nrst = 1;
        repeat (8) @(negedge mclk);
        chain_enable_n = 0;
        for (int c = 0; c < 7; c++) begin
            while (config_active !== 1'b1) @(negedge mclk);
            repeat (2) m.tick(1'b0);
            oks = 0;
            repeat (2) m.send_frame({$urandom, $urandom}, 0);
            repeat (9) @(negedge mclk);
            chk(frame_count, 8'h02);
            chk(8'(oks), 8'h02);
            errs = 0;
            lows = 0;
            ticks = 0;
            case (c)
                0, 1: m.send_frame({$urandom, $urandom}, c + 1);
                2: m.finish_load(64);
                3: m.finish_load(16);
                4: supply_ok = 0;
                5: begin
                    supply_ok = 0;
                    config_request_n = 0;
                end
                default: scan_active = 1;
            endcase
            repeat (20) @(negedge mclk);
            chk(8'(lows > 0), 8'h01);
            chk(8'(errs > 0), 8'(c < 6));
            chk(frame_count, 8'h00);
            chk(8'(oks), 8'h02);
            if (c == 2) chk(8'(waited), 8'h40);
            if (c == 3) chk(8'(waited), 8'h10);
            // Request low unless tied high, so idle link edges never count as frame bits
            config_request_n = (c == 4);
            repeat (6) @(negedge mclk);
            repeat (2) m.tick(1'b0);
            @(negedge mclk);
            supply_ok = 1;
            scan_active = 0;
            if (c == 5) begin
                repeat (60) @(negedge mclk);
                chk(8'(config_active), 8'h00);
            end
            config_request_n = 1;
        end
        complete_run();
    end
endmodule
